/* File: hdl/pds_params.svh */
// Purpose: Register map, field positions and reset values of the PWM protect block
// Assumes: Included by bare name from every design file that needs it
// Notes:   Definitions only
`ifndef PDS_PARAMS_SVH
`define PDS_PARAMS_SVH

// Register indices on the plain register port
`define PDS_ADDR_W          3
`define PDS_OFF_DB          3'h0
`define PDS_OFF_SD          3'h1
`define PDS_OFF_CFG         3'h2
`define PDS_OFF_IST         3'h3
`define PDS_OFF_IMSK        3'h4
`define PDS_OFF_STATE       3'h5

// Dead-band / restart register fields
`define PDS_DC_W            7
`define PDS_DC_MSB          6
`define PDS_RSEN_BIT        7

// Shutdown control register fields
`define PDS_FLAG_BIT        7
`define PDS_SRC_MSB         6
`define PDS_SRC_LSB         4
`define PDS_SRC_CMP1        0
`define PDS_SRC_CMP2        1
`define PDS_SRC_FLT         2
`define PDS_BD_MSB          3
`define PDS_BD_LSB          2
`define PDS_AC_MSB          1

// Configuration register fields
`define PDS_CFG_MSB         1
`define PDS_ENH_BIT         2

// Interrupt status / mask layout
`define PDS_IRQ_W           3
`define PDS_IRQ_SHUT        0
`define PDS_IRQ_AUTOCLR     1
`define PDS_IRQ_RESUME      2

// Reset values
`define PDS_RST_BYTE        8'h00
`define PDS_RST_IRQ         3'h0
`define PDS_RST_SYNC        3'h4

`endif

/* File: hdl/pds_pkg.sv */
// Purpose: Types shared by the PWM protect block
// Assumes: Nothing beyond SystemVerilog packed types
// Notes:   Enumerations and carriers only; numbers live in pds_params.svh
package pds_pkg;

    typedef enum logic [1:0] {
        PDS_CFG_SINGLE = 2'h0,
        PDS_CFG_HALF   = 2'h1,
        PDS_CFG_FWD    = 2'h3,
        PDS_CFG_REV    = 2'h2
    } pds_cfg_t;

    // Per-pair shutdown drive choice
    typedef enum logic [1:0] {
        PDS_SD_LOW  = 2'h0,
        PDS_SD_HIGH = 2'h1,
        PDS_SD_TRI  = 2'h2,
        PDS_SD_TRI2 = 2'h3
    } pds_sd_state_t;

    // Pin order is {d, c, b, a}
    typedef struct packed {
        logic [3:0] lvl;
        logic [3:0] oe;
    } pds_pins_t;

    typedef struct packed {
        logic          flag;
        logic [2:0]    src;
        pds_sd_state_t bd;
        pds_sd_state_t ac;
    } pds_sdctl_t;

endpackage : pds_pkg

/* File: hdl/pds_deadband.sv */
// Purpose: Delays the inactive-to-active edge of one PWM drive signal
// Assumes: clk_i is the instruction clock; level_i comes from the same clock
// Notes:   Falling edges pass straight through; output is combinational
`timescale 1ns/1ps
`default_nettype none
`include "pds_params.svh"

module pds_deadband #(
    parameter int unsigned CNT_W = `PDS_DC_W
) (
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             level_i,
    input  wire logic [CNT_W-1:0] count_i,
    output logic                  level_o
);

    logic [CNT_W-1:0] held_r;
    logic [CNT_W-1:0] held_nxt;
    wire              reached;

    // Counts active cycles; stops once the delay is spent so it cannot wrap
    assign reached  = (held_r >= count_i);                           // [RQ14]
    assign held_nxt = !level_i ? '0 :
                      (reached ? held_r : CNT_W'(held_r + 1'b1));
    // Active only after the delay, inactive at once; zero count means no delay
    assign level_o  = level_i & reached;                             // [RQ1] [RQ17]

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            held_r <= '0;
        end else begin
            held_r <= held_nxt;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_rise2;
        $rose(level_i) && count_i == CNT_W'(2);
    endsequence
    sequence s_keep2;
        level_i && count_i == CNT_W'(2);
    endsequence

    a_db_late_rise: assert property (s_rise2 ##1 s_keep2 ##1 s_keep2 |-> // [RQ14]
        level_o && !$past(level_o) && !$past(level_o, 2))
        else $error("dead-band of two cycles not honoured");
    a_db_fast_fall: assert property (!level_i |-> !level_o) // [RQ1]
        else $error("inactive edge was delayed");
    a_db_zero_cnt: assert property (level_i && count_i == '0 |-> level_o) // [RQ17]
        else $error("zero dead-band count still delayed output");

endmodule : pds_deadband
`default_nettype wire

/* File: hdl/pds_pwm_protect.sv */
// Purpose: Dead-band insertion and auto-shutdown for an enhanced PWM output stage
// Assumes: clk_i is the instruction clock; pwm_level_i and period_match_i from the
//          duty/period core on the same clock; comparators and fault pin are async
// Notes:   Pins and register read data are registered, one cycle behind their cause
// Notes on behaviour
// RQ1: Half-bridge delays only inactive-to-active edges; falling edges pass undelayed.
// RQ2: Dead-band length is seven-bit count in low bits, instruction cycles.
// RQ3: Auto-shutdown works in enhanced modes, forcing pins without waiting for period end.
// RQ4: Three-bit source field selects comparators and fault pin; none disables shutdown.
// RQ5: Enabled fault input low counts as a shutdown event.
// RQ6: Shutdown drives pins per pair A/C and B/D: high, low or tri-state.
// RQ7: Hardware sets shutdown flag on event; while set, pins stay in shutdown.
// RQ8: Without auto restart, software clears the flag after the cause is gone.
// RQ9: With auto restart, hardware clears the flag once the cause has cleared.
// RQ10: Flag set at period start keeps pins shut for that whole period.
// RQ11: After flag clears, normal PWM resumes only at the next period start.
// RQ12: Software writes to the flag are ignored while a shutdown condition exists.
// RQ13: Bit seven of dead-band register enables automatic restart.
// RQ14: Dead-band count is delay from scheduled to actual active edge.
// RQ15: Period timer match ends one period and starts the next.
// RQ16: Two-bit config selects single, half, full forward, full reverse; dead-band half only.
// RQ17: Dead-band count zero gives no delay at all.
`timescale 1ns/1ps
`default_nettype none
`include "pds_params.svh"

module pds_pwm_protect #(
    parameter int unsigned DC_W = `PDS_DC_W
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_b_i,
    input  wire logic [`PDS_ADDR_W-1:0] reg_addr_i,
    input  wire logic [7:0]            reg_wdata_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    output logic      [7:0]            reg_rdata_o,
    input  wire logic                  pwm_level_i,
    input  wire logic                  period_match_i,
    input  wire logic                  cmp1_i,
    input  wire logic                  cmp2_i,
    input  wire logic                  fault_input_n_i,
    output logic      [3:0]            pwm_out_o,
    output logic      [3:0]            pwm_oe_o,
    output logic                       irq_o
);

    function automatic logic reg_hit(input logic [`PDS_ADDR_W-1:0] addr,
                                     input logic [`PDS_ADDR_W-1:0] off);
        reg_hit = (addr == off);
    endfunction : reg_hit

    // Pair drive: {level, enable}; both tri-state codes release the pin
    function automatic logic [1:0] sd_drive(input pds_pkg::pds_sd_state_t st);
        case (st)
            pds_pkg::PDS_SD_LOW:  sd_drive = 2'h1;
            pds_pkg::PDS_SD_HIGH: sd_drive = 2'h3;
            default:              sd_drive = 2'h0;
        endcase
    endfunction : sd_drive

    // Registers
    logic                  auto_restart_enable_r;
    logic [DC_W-1:0]       deadband_count_r;
    pds_pkg::pds_sdctl_t   sdctl_r;
    pds_pkg::pds_cfg_t     output_config_select_r;
    logic                  enh_r;
    logic [`PDS_IRQ_W-1:0] ist_r;
    logic [`PDS_IRQ_W-1:0] ist_nxt;
    logic [`PDS_IRQ_W-1:0] imsk_r;
    logic                  flag_nxt;
    logic                  hold_r;
    logic                  hold_nxt;
    logic [7:0]            rdata_nxt;
    logic [7:0]            rd_mux;

    // Input synchronisers: meta stage feeds only the second stage
    logic [2:0]            in_meta_r;
    logic [2:0]            in_sync_r;

    // Pin computation
    pds_pkg::pds_pins_t    norm_pins;
    pds_pkg::pds_pins_t    sd_pins;
    pds_pkg::pds_pins_t    pins_nxt;
    logic [1:0]            db_in;
    logic [1:0]            db_out;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            in_meta_r <= `PDS_RST_SYNC;
            in_sync_r <= `PDS_RST_SYNC;
        end else begin
            in_meta_r <= {fault_input_n_i, cmp2_i, cmp1_i};
            in_sync_r <= in_meta_r;
        end
    end

    // Bus decode
    wire wr_db   = reg_wr_i && reg_hit(reg_addr_i, `PDS_OFF_DB);
    wire wr_sd   = reg_wr_i && reg_hit(reg_addr_i, `PDS_OFF_SD);
    wire wr_cfg  = reg_wr_i && reg_hit(reg_addr_i, `PDS_OFF_CFG);
    wire wr_ist  = reg_wr_i && reg_hit(reg_addr_i, `PDS_OFF_IST);
    wire wr_imsk = reg_wr_i && reg_hit(reg_addr_i, `PDS_OFF_IMSK);

    // Shutdown sources; fault pin is active low
    wire [2:0] src_level = {~in_sync_r[`PDS_SRC_FLT],                   // [RQ5]
                            in_sync_r[`PDS_SRC_CMP2],
                            in_sync_r[`PDS_SRC_CMP1]};
    wire [2:0] src_hit   = src_level & sdctl_r.src;                     // [RQ4]
    // Condition only exists in enhanced modes; empty source field never fires
    wire       sd_cond   = enh_r && (|src_hit);                         // [RQ3] [RQ4]

    // Flag: event sets, auto restart clears when cause is gone, software
    // writes land only while no condition is present
    wire flag_hw_clr = sdctl_r.flag && auto_restart_enable_r && !sd_cond; // [RQ9] [RQ13]
    wire flag_sw_wr  = wr_sd && !sd_cond;                               // [RQ12] [RQ8]
    assign flag_nxt = sd_cond     ? 1'b1 :                              // [RQ7]
                      flag_hw_clr ? 1'b0 :
                      flag_sw_wr  ? reg_wdata_i[`PDS_FLAG_BIT] :
                      sdctl_r.flag;

    // Hold enters at once on a condition, and is re-evaluated only at the
    // period boundary, so a cleared flag waits for the next period
    assign hold_nxt = sd_cond        ? 1'b1 :                           // [RQ3]
                      period_match_i ? flag_nxt :                       // [RQ10] [RQ11] [RQ15]
                      hold_r;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            auto_restart_enable_r <= 1'b0;
            deadband_count_r      <= '0;
        end else if (wr_db) begin
            auto_restart_enable_r <= reg_wdata_i[`PDS_RSEN_BIT];        // [RQ13]
            deadband_count_r      <= reg_wdata_i[`PDS_DC_MSB:0];        // [RQ2]
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sdctl_r <= pds_pkg::pds_sdctl_t'(`PDS_RST_BYTE);
        end else begin
            sdctl_r.flag <= flag_nxt;
            if (wr_sd) begin
                sdctl_r.src <= reg_wdata_i[`PDS_SRC_MSB:`PDS_SRC_LSB];
                sdctl_r.bd  <= pds_pkg::pds_sd_state_t'(reg_wdata_i[`PDS_BD_MSB:`PDS_BD_LSB]);
                sdctl_r.ac  <= pds_pkg::pds_sd_state_t'(reg_wdata_i[`PDS_AC_MSB:0]);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            output_config_select_r <= pds_pkg::PDS_CFG_SINGLE;
            enh_r                  <= 1'b0;
        end else if (wr_cfg) begin
            output_config_select_r <= pds_pkg::pds_cfg_t'(reg_wdata_i[`PDS_CFG_MSB:0]); // [RQ16]
            enh_r                  <= reg_wdata_i[`PDS_ENH_BIT];
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hold_r <= 1'b0;
        end else begin
            hold_r <= hold_nxt;
        end
    end

    // Interrupt events; a set in the clearing cycle survives
    wire [`PDS_IRQ_W-1:0] ist_set = {hold_r && !hold_nxt,
                                     flag_hw_clr,
                                     sd_cond && !sdctl_r.flag};
    wire [`PDS_IRQ_W-1:0] ist_clr = wr_ist ? reg_wdata_i[`PDS_IRQ_W-1:0] : `PDS_RST_IRQ;
    assign ist_nxt = (ist_r & ~ist_clr) | ist_set;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ist_r  <= `PDS_RST_IRQ;
            imsk_r <= `PDS_RST_IRQ;
            irq_o  <= 1'b0;
        end else begin
            ist_r  <= ist_nxt;
            irq_o  <= |(ist_nxt & imsk_r);
            if (wr_imsk) begin
                imsk_r <= reg_wdata_i[`PDS_IRQ_W-1:0];
            end
        end
    end

    // Dead-band units for the complementary half-bridge pair A/B
    assign db_in = {~pwm_level_i, pwm_level_i};

    generate
        for (genvar g = 0; g < 2; g++) begin : g_db
            pds_deadband #(
                .CNT_W   (DC_W)
            ) u_db (
                .clk_i   (clk_i),
                .rst_b_i (rst_b_i),
                .level_i (db_in[g]),
                .count_i (deadband_count_r),                            // [RQ2] [RQ14]
                .level_o (db_out[g])
            );
        end
    endgenerate

    // Normal drive per configuration; only half-bridge sees the dead-band
    always_comb begin
        norm_pins = '0;
        if (enh_r) begin
            case (output_config_select_r)                               // [RQ16]
                pds_pkg::PDS_CFG_SINGLE: begin
                    norm_pins.lvl = {3'h0, pwm_level_i};
                    norm_pins.oe  = 4'h1;
                end
                pds_pkg::PDS_CFG_HALF: begin
                    norm_pins.lvl = {2'h0, db_out};                     // [RQ1]
                    norm_pins.oe  = 4'h3;
                end
                pds_pkg::PDS_CFG_FWD: begin
                    norm_pins.lvl = {pwm_level_i, 2'h0, 1'b1};
                    norm_pins.oe  = 4'hf;
                end
                pds_pkg::PDS_CFG_REV: begin
                    norm_pins.lvl = {1'b0, 1'b1, pwm_level_i, 1'b0};
                    norm_pins.oe  = 4'hf;
                end
                default: begin
                    norm_pins = '0;
                end
            endcase
        end
    end

    // Shutdown drive of the pins in use; A/C share one pair setting, B/D the other
    wire [1:0] drv_ac = sd_drive(sdctl_r.ac);                           // [RQ6]
    wire [1:0] drv_bd = sd_drive(sdctl_r.bd);                           // [RQ6]
    assign sd_pins.lvl = {drv_bd[1], drv_ac[1], drv_bd[1], drv_ac[1]};
    assign sd_pins.oe  = norm_pins.oe & {drv_bd[0], drv_ac[0], drv_bd[0], drv_ac[0]};
    assign pins_nxt    = hold_nxt ? sd_pins : norm_pins;                // [RQ7] [RQ3]

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pwm_out_o <= 4'h0;
            pwm_oe_o  <= 4'h0;
        end else begin
            pwm_out_o <= pins_nxt.lvl & pins_nxt.oe;
            pwm_oe_o  <= pins_nxt.oe;
        end
    end

    // Read mux; data stands only in the cycle after the strobe
    assign rd_mux =
        reg_hit(reg_addr_i, `PDS_OFF_DB)    ? {auto_restart_enable_r, deadband_count_r} :
        reg_hit(reg_addr_i, `PDS_OFF_SD)    ? 8'(sdctl_r) :
        reg_hit(reg_addr_i, `PDS_OFF_CFG)   ? {5'h00, enh_r, output_config_select_r} :
        reg_hit(reg_addr_i, `PDS_OFF_IST)   ? {5'h00, ist_r} :
        reg_hit(reg_addr_i, `PDS_OFF_IMSK)  ? {5'h00, imsk_r} :
        reg_hit(reg_addr_i, `PDS_OFF_STATE) ? {3'h0, sd_cond, hold_r, src_level} :
                                              `PDS_RST_BYTE;
    assign rdata_nxt = reg_rd_i ? rd_mux : `PDS_RST_BYTE;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= `PDS_RST_BYTE;
        end else begin
            reg_rdata_o <= rdata_nxt;
        end
    end

    // Checks; they watch internal state as well as pins, so a failure
    // points at the register that caused it
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_event;
        sd_cond;
    endsequence
    sequence s_period_shut;
        period_match_i && sdctl_r.flag && !flag_hw_clr && !flag_sw_wr;
    endsequence
    sequence s_gone_auto;
        sdctl_r.flag && auto_restart_enable_r && !sd_cond;
    endsequence

    // Flag and hold sequencing
    a_flag_on_event: assert property (s_event |=> sdctl_r.flag && hold_r) // [RQ7]
        else $error("shutdown event did not set flag and hold");

    a_no_src_quiet: assert property (sdctl_r.src == 3'h0 |-> !sd_cond) // [RQ4]
        else $error("shutdown fired with no source selected");

    a_fault_low_trip: assert property ( // [RQ5]
        enh_r && sdctl_r.src[`PDS_SRC_FLT] && !in_sync_r[`PDS_SRC_FLT] |-> sd_cond)
        else $error("low fault input not treated as shutdown");

    a_restart_auto_clr: assert property (s_gone_auto |=> !sdctl_r.flag) // [RQ9]
        else $error("auto restart failed to clear flag");

    a_manual_keeps: assert property ( // [RQ8]
        sdctl_r.flag && !auto_restart_enable_r && !wr_sd |=> sdctl_r.flag)
        else $error("flag cleared without software in manual mode");

    a_write_locked: assert property (sd_cond && wr_sd |=> sdctl_r.flag) // [RQ12]
        else $error("software write reached flag during shutdown");

    a_whole_period: assert property (s_period_shut |=> hold_r) // [RQ10]
        else $error("outputs released while flag set at period start");

    a_resume_bound: assert property ( // [RQ11]
        $fell(hold_r) |-> $past(period_match_i) && !sdctl_r.flag)
        else $error("outputs resumed outside a period boundary");

    a_hold_waits: assert property ( // [RQ11] [RQ15]
        hold_r && !period_match_i |=> hold_r)
        else $error("outputs left shutdown between period boundaries");

    // Pin drive
    a_shut_pins: assert property ( // [RQ6]
        s_event |=> (pwm_oe_o & ~$past(norm_pins.oe)) == 4'h0 ##0 pwm_oe_o == $past(sd_pins.oe))
        else $error("pins not in shutdown drive after event");

    a_plain_idle: assert property (!enh_r |=> pwm_oe_o == 4'h0) // [RQ3] [RQ16]
        else $error("pins driven outside enhanced modes");

    a_full_no_delay: assert property ( // [RQ16]
        enh_r && output_config_select_r == pds_pkg::PDS_CFG_FWD && !hold_nxt
        |=> pwm_out_o[3] == $past(pwm_level_i))
        else $error("full-bridge output was delayed");

    // Both switches of one leg on would short the bridge supply
    a_half_apart: assert property ( // [RQ1]
        !hold_r |-> !(pwm_out_o[0] && pwm_out_o[1]))
        else $error("both switches of leg A/B driven active");

    // Register and interrupt
    a_count_load: assert property ( // [RQ2] [RQ13]
        wr_db |=> {auto_restart_enable_r, deadband_count_r} == $past(reg_wdata_i))
        else $error("dead-band register write did not land");

    a_irq_level: assert property (irq_o == |($past(ist_nxt) & $past(imsk_r)))
        else $error("interrupt output disagrees with status and mask");

endmodule : pds_pwm_protect
`default_nettype wire

/* File: test/pds_bridge_model.sv */
// Purpose: Behavioural half/full bridge gate driver on the far side of the PWM pins
// Assumes: Gate inputs carry pull-downs; trip_i stands for the current comparator
// Notes:   Counts cycles where both switches of leg A/B are on at once
`timescale 1ns/1ps
`default_nettype none

module pds_bridge_model (
    input  wire logic       clk_i,
    input  wire logic [3:0] pin_i,
    input  wire logic [3:0] oe_i,
    input  wire logic       trip_i,
    output logic      [3:0] gate_o,
    output logic            cmp_o,
    output var int          shoot_o
);
    // Undriven gate inputs fall to the pull-down level, never hold the last value
    assign gate_o = pin_i & oe_i;
    assign cmp_o  = trip_i;

    initial shoot_o = 0;

    // Overlap of both switches would short the bridge supply
    always @(posedge clk_i) begin
        if (gate_o[0] && gate_o[1]) begin
            shoot_o <= shoot_o + 1;
        end
    end
endmodule : pds_bridge_model

`default_nettype wire

/* File: test/pds_pwm_protect_tb.sv */
// Purpose: Self-checking bench for dead-band, auto-shutdown and interrupts
// Assumes: 125 MHz clock; async sources seen through two sync flops
// Notes:   Pin checks allow the registered one-cycle latency of the pins
`timescale 1ns/1ps
`default_nettype none
`include "pds_params.svh"

`define CHK(g, e) \
    begin \
        cmp_count++; \
        if ((g) !== (e)) begin \
            failures++; \
            $display("ERROR %0t: got %0h expected %0h", $time, (g), (e)); \
        end \
    end

module pds_pwm_protect_tb;
    logic       clk_i;
    logic       rst_b_i;
    logic [2:0] reg_addr_i;
    logic [7:0] reg_wdata_i;
    logic       reg_wr_i;
    logic       reg_rd_i;
    logic [7:0] reg_rdata_o;
    logic       pwm_level_i;
    logic       period_match_i;
    logic       cmp1_i;
    logic       cmp2_i;
    logic       fault_input_n_i;
    logic [3:0] pwm_out_o;
    logic [3:0] pwm_oe_o;
    logic       irq_o;
    logic       trip_i;
    int         shoot;
    int         failures = 0;
    int         cmp_count = 0;

    pds_pwm_protect #(.DC_W(`PDS_DC_W)) dut_u (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .pwm_level_i(pwm_level_i),
        .period_match_i(period_match_i), .cmp1_i(cmp1_i), .cmp2_i(cmp2_i),
        .fault_input_n_i(fault_input_n_i), .pwm_out_o(pwm_out_o),
        .pwm_oe_o(pwm_oe_o), .irq_o(irq_o));

    pds_bridge_model bridge_u (
        .clk_i(clk_i), .pin_i(pwm_out_o), .oe_i(pwm_oe_o), .trip_i(trip_i),
        .gate_o(), .cmp_o(cmp1_i), .shoot_o(shoot));

    task automatic conclude();
        if (failures == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    task automatic chk_rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1;
        `CHK(reg_rdata_o, e)
    endtask : chk_rd

    // Bounded wait for a pin pattern; n is the number of edges it took
    task automatic wait_pins(input logic [3:0] o, input logic [3:0] e, input int lim,
                             output int n);
        for (n = 1; n <= lim; n++) begin
            @(posedge clk_i);
            #1;
            if (pwm_out_o === o && pwm_oe_o === e) break;
        end
        `CHK({pwm_out_o, pwm_oe_o}, {o, e})
        if (n > lim) conclude();
    endtask : wait_pins

    task automatic pulse_match();
        @(posedge clk_i);
        period_match_i <= 1'b1;
        @(posedge clk_i);
        period_match_i <= 1'b0;
    endtask : pulse_match

    task automatic t_regs();
        for (int i = 0; i < 8; i++) begin
            chk_rd(i[2:0], 8'h00);
        end
        wr(3'h6, 8'hff);
        chk_rd(3'h6, 8'h00);
        wr(`PDS_OFF_STATE, 8'hff);
        chk_rd(`PDS_OFF_STATE, 8'h00);
        wr(`PDS_OFF_DB, 8'h83);
        chk_rd(`PDS_OFF_DB, 8'h83);
        wr(`PDS_OFF_CFG, 8'hff);
        chk_rd(`PDS_OFF_CFG, 8'h07);
    endtask : t_regs

    task automatic t_modes();
        logic [7:0] cfg [4] = '{8'h04, 8'h05, 8'h07, 8'h06};
        logic [3:0] po  [4] = '{4'h1, 4'h1, 4'h9, 4'h6};
        logic [3:0] pe  [4] = '{4'h1, 4'h3, 4'hf, 4'hf};
        int n;
        wr(`PDS_OFF_DB, 8'h00);
        pwm_level_i <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(`PDS_OFF_CFG, cfg[i]);
            wait_pins(po[i], pe[i], 4, n);
        end
    endtask : t_modes

    task automatic t_deadband();
        int cnt [3] = '{0, 2, 127};
        int n;
        for (int i = 0; i < 3; i++) begin
            wr(`PDS_OFF_DB, cnt[i][7:0]);
            pwm_level_i <= 1'b0;
            wait_pins(4'h2, 4'h3, 140, n);
            @(posedge clk_i);
            pwm_level_i <= 1'b1;
            wait_pins(4'h1, 4'h3, 140, n);
            `CHK(n, cnt[i] + 1)
            @(posedge clk_i);
            pwm_level_i <= 1'b0;
            @(posedge clk_i);
            #1;
            `CHK(pwm_out_o[0], 1'b0)
        end
        wr(`PDS_OFF_DB, 8'h00);
        wait_pins(4'h2, 4'h3, 140, n);
    endtask : t_deadband

    // Comparator trip, software restart, interrupt raise/mask/clear
    task automatic t_sw_restart();
        int n;
        wr(`PDS_OFF_IMSK, 8'h01);
        wr(`PDS_OFF_SD, 8'h19);
        trip_i <= 1'b1;
        wait_pins(4'h1, 4'h1, 6, n);
        chk_rd(`PDS_OFF_SD, 8'h99);
        chk_rd(`PDS_OFF_STATE, 8'h19);
        `CHK(irq_o, 1'b1)
        wr(`PDS_OFF_SD, 8'h19);
        chk_rd(`PDS_OFF_SD, 8'h99);
        pulse_match();
        repeat (4) @(posedge clk_i);
        #1;
        `CHK({pwm_out_o, pwm_oe_o}, 8'h11)
        trip_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk_rd(`PDS_OFF_SD, 8'h99);
        wr(`PDS_OFF_IMSK, 8'h00);
        @(posedge clk_i);
        #1;
        `CHK(irq_o, 1'b0)
        wr(`PDS_OFF_SD, 8'h19);
        chk_rd(`PDS_OFF_SD, 8'h19);
        repeat (4) @(posedge clk_i);
        #1;
        `CHK({pwm_out_o, pwm_oe_o}, 8'h11)
        pulse_match();
        wait_pins(4'h2, 4'h3, 1, n);
        chk_rd(`PDS_OFF_IST, 8'h05);
        wr(`PDS_OFF_IMSK, 8'h01);
        @(posedge clk_i);
        #1;
        `CHK(irq_o, 1'b1)
        wr(`PDS_OFF_IST, 8'h07);
        chk_rd(`PDS_OFF_IST, 8'h00);
        `CHK(irq_o, 1'b0)
    endtask : t_sw_restart

    // Each source alone with hardware restart, then no source selected
    task automatic t_sources();
        logic [7:0] src;
        int n;
        wr(`PDS_OFF_DB, 8'h80);
        pwm_level_i <= 1'b1;
        wait_pins(4'h1, 4'h3, 4, n);
        for (int i = 0; i < 3; i++) begin
            src = 8'h10 << i;
            wr(`PDS_OFF_SD, 8'h04 | src);
            trip_i          <= (i == 0);
            cmp2_i          <= (i == 1);
            fault_input_n_i <= (i != 2);
            wait_pins(4'h2, 4'h3, 6, n);
            chk_rd(`PDS_OFF_SD, 8'h84 | src);
            trip_i          <= 1'b0;
            cmp2_i          <= 1'b0;
            fault_input_n_i <= 1'b1;
            repeat (5) @(posedge clk_i);
            chk_rd(`PDS_OFF_SD, 8'h04 | src);
            `CHK({pwm_out_o, pwm_oe_o}, 8'h23)
            pulse_match();
            wait_pins(4'h1, 4'h3, 1, n);
        end
        chk_rd(`PDS_OFF_IST, 8'h07);
        wr(`PDS_OFF_SD, 8'h04);
        trip_i          <= 1'b1;
        cmp2_i          <= 1'b1;
        fault_input_n_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk_rd(`PDS_OFF_SD, 8'h04);
        `CHK({pwm_out_o, pwm_oe_o}, 8'h13)
        trip_i          <= 1'b0;
        cmp2_i          <= 1'b0;
        fault_input_n_i <= 1'b1;
    endtask : t_sources

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    initial begin
        #400000;
        failures++;
        conclude();
    end

    initial begin
        rst_b_i         = 1'b0;
        reg_addr_i      = 3'h0;
        reg_wdata_i     = 8'h00;
        reg_wr_i        = 1'b0;
        reg_rd_i        = 1'b0;
        pwm_level_i     = 1'b0;
        period_match_i  = 1'b0;
        cmp2_i          = 1'b0;
        fault_input_n_i = 1'b1;
        trip_i          = 1'b0;
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_regs();
        t_modes();
        wr(`PDS_OFF_CFG, 8'h05);
        t_deadband();
        t_sw_restart();
        t_sources();
        `CHK(shoot, 0)
        conclude();
    end
endmodule : pds_pwm_protect_tb

`default_nettype wire
